//--- shared/srsg_params.svh
// Offsets, field positions, reset values and timing figures of the step generator
`ifndef SRSG_PARAMS_SVH
`define SRSG_PARAMS_SVH

`define SRSG_CLK_HZ        40000000
`define SRSG_TICK_HZ       8000000
`define SRSG_TICK_DIV      (`SRSG_CLK_HZ / `SRSG_TICK_HZ)

`define SRSG_OFF_CTRL      8'h00
`define SRSG_OFF_CFG       8'h04
`define SRSG_OFF_START     8'h08
`define SRSG_OFF_TARGET    8'h0c
`define SRSG_OFF_STOP      8'h10
`define SRSG_OFF_ACCEL     8'h14
`define SRSG_OFF_STEPS     8'h18
`define SRSG_OFF_STOP_AT   8'h1c
`define SRSG_OFF_REF_A     8'h20
`define SRSG_OFF_REF_B     8'h24
`define SRSG_OFF_STATUS    8'h28
`define SRSG_OFF_SPEED     8'h2c
`define SRSG_OFF_COUNT     8'h30
`define SRSG_OFF_ACK       8'h34

`define SRSG_CMD_START     0
`define SRSG_CMD_STOP      1
`define SRSG_CMD_MOVE      2
`define SRSG_CMD_UPDATE    3

`define SRSG_CFG_W         10
`define SRSG_REF_W         12

`define SRSG_RST_SPEED     16'h9c40
`define SRSG_RST_TARGET    16'h1f40
`define SRSG_RST_ACCEL     16'h0032
`define SRSG_RST_STEPS     16'h03e8
`define SRSG_RST_STOP_AT   16'h0320
`define SRSG_ACCEL_MAX     16'h1388
`define SRSG_UPD_BASE      16'h1389

`define SRSG_RES_INT_MAX   4'h5
`define SRSG_RES_EXT_MIN   4'h1
`define SRSG_RES_EXT_MAX   4'h9
`define SRSG_FULL_INC      11'h200
`define SRSG_ACK_SEQ       24'h31_3030
`define SRSG_RESP_OKAY     2'h0
`define SRSG_RESP_SLVERR   2'h2

`endif

//--- shared/srsg_pkg.sv
// Types shared by the step generator modules
package srsg_pkg;

  typedef enum logic [3:0] {
    st_idle  = 4'b0001,
    st_accel = 4'b0010,
    st_run   = 4'b0100,
    st_decel = 4'b1000
  } srsg_state_t;

  typedef struct packed {
    logic [3:0] res;
    logic       ext_indexer;
    logic       mode_cfg;
    logic       awake;
    logic       decay_b;
    logic       decay_a;
    logic       dir;
  } srsg_cfg_t;

  typedef struct packed {
    logic [15:0] start;
    logic [15:0] target;
    logic [15:0] stop;
    logic [15:0] accel;
    logic [15:0] steps;
    logic [15:0] stop_at;
  } srsg_prof_t;

endpackage

//--- hdl/srsg_wave_rom.sv
// Quarter-wave current table with two registered read ports
`timescale 1ns/100ps
`default_nettype none
module srsg_wave_rom #(
  parameter int AW = 9,
  parameter int DW = 12
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          clk_en,
  input  wire logic [AW-1:0] addr_a,
  input  wire logic [AW-1:0] addr_b,
  output logic      [DW-1:0] data_a,
  output logic      [DW-1:0] data_b
);
  logic [DW-1:0] mem [0:(2**AW)-1];

  // Parabolic fit of a rising quarter sine, full scale at the top
  function automatic logic [DW-1:0] wave(input longint i);
    longint n;
    n = longint'(2**AW);
    return DW'(((longint'(2**DW) - 1) * i * (2 * n - i)) / (n * n));
  endfunction

  // Table is fixed content, built once
  initial begin
    for (int i = 0; i < 2**AW; i++) begin
      mem[i] = wave(longint'(i));
    end
  end

  // Registered reads so the table maps onto block memory
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_a <= '0;
      data_b <= '0;
    end else if (clk_en) begin
      data_a <= mem[addr_a];
      data_b <= mem[addr_b];
    end
  end
endmodule
`default_nettype wire

//--- hdl/srsg_step_timer.sv
// Time base and step interval counter
`timescale 1ns/100ps
`default_nettype none
`include "srsg_params.svh"
module srsg_step_timer #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  input  wire logic         run,
  input  wire logic [W-1:0] period,
  output logic              tick,
  output logic              step_evt,
  output logic              step_out
);
  localparam logic [7:0] DIV_M1 = 8'(`SRSG_TICK_DIV - 1);

  logic [7:0]   pre;
  logic [W-1:0] cnt;
  wire          pre_wrap = (pre == DIV_M1);
  wire          expire   = run & tick & (cnt <= W'(1));

  // Prescaler makes the timer tick from the system clock
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pre  <= '0;
      tick <= 1'b0;
    end else if (clk_en) begin
      pre  <= pre_wrap ? 8'h00 : pre + 8'h01;
      tick <= pre_wrap;
    end
  end

  // Interval counter reloads from the live period at each step
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt      <= '0;
      step_evt <= 1'b0;
      step_out <= 1'b0;
    end else if (clk_en) begin
      step_evt <= expire;
      if (!run) begin
        cnt <= period;
      end else if (tick) begin
        cnt <= (cnt <= W'(1)) ? period : cnt - W'(1);
      end
      // Pulse lasts four clocks, set after the event and cleared by the next tick
      if (step_evt) begin
        step_out <= 1'b1;
      end else if (tick) begin
        step_out <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- hdl/srsg_top.sv
// Trapezoidal step generator with register slave and driver control lines
//
// Notes on behaviour
// - Step timing counts an 8 MHz tick derived from the system clock.
// - Start command begins stepping at the start-speed interval.
// - Start computes an update interval; a second timer ramps the step rate.
// - At target speed acceleration ends; stepping continues until stop.
// - Stop ramps down mirroring acceleration to stop speed, then halts.
// - Move command issues exactly the programmed count of steps, then halts.
// - Motion always begins through the acceleration ramp, never at full speed.
// - Direction and resolution settings drive the driver; decay settings do so only in internal indexer mode.
// - Each control line is high when set, low when cleared.
// - Two 12-bit current reference codes, 0 to 4095, full scale 2.5 V.
// - External indexer mode takes references from the microstep table.
// - Each accepted command returns the three-character acknowledgement.
// - Resolution full to 1/32 internal, half to 1/512 external.
// - Move decelerates at steps-to-stop; beyond total steps, abrupt stop.
// - Move ends at current rate if steps run out; else holds stop speed.
//
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "srsg_params.svh"
module srsg_top #(
  parameter int W  = 16,
  parameter int AW = 8
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          clk_en,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  output logic               step_pulse,
  output logic               direction,
  output logic               channel_a_decay_select,
  output logic               channel_b_decay_select,
  output logic               mode_config,
  output logic               driver_awake,
  output logic [3:0]         microstep_res,
  output logic [11:0]        channel_a_reference,
  output logic [11:0]        channel_b_reference
);
  import srsg_pkg::*;

  srsg_cfg_t    cfg;
  srsg_prof_t   prog, act;
  srsg_state_t  state, next_state;
  logic [W-1:0] cur_period, next_period, steps_done, next_steps, upd_cnt;
  logic         is_move, next_is_move;
  logic [11:0]  ref_a, ref_b;
  logic [7:0]   ack_count;
  logic [10:0]  phase;
  logic         aw_hold, w_hold;
  logic [AW-1:0] aw_addr_q;
  logic [31:0]  wdata_q;
  logic [3:0]   wstrb_q;
  logic         tick, step_evt;
  logic [11:0]  rom_a, rom_b;

  // Address decode, shared by the read path and the write merge
  function automatic logic reg_known(input logic [AW-1:0] a);
    return (a[1:0] == 2'b00) && (a <= `SRSG_OFF_ACK);
  endfunction

  function automatic logic [31:0] reg_word(input logic [AW-1:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a == `SRSG_OFF_CFG) begin
      v = 32'(cfg);
    end else if (a == `SRSG_OFF_START) begin
      v = 32'(prog.start);
    end else if (a == `SRSG_OFF_TARGET) begin
      v = 32'(prog.target);
    end else if (a == `SRSG_OFF_STOP) begin
      v = 32'(prog.stop);
    end else if (a == `SRSG_OFF_ACCEL) begin
      v = 32'(prog.accel);
    end else if (a == `SRSG_OFF_STEPS) begin
      v = 32'(prog.steps);
    end else if (a == `SRSG_OFF_STOP_AT) begin
      v = 32'(prog.stop_at);
    end else if (a == `SRSG_OFF_REF_A) begin
      v = 32'(ref_a);
    end else if (a == `SRSG_OFF_REF_B) begin
      v = 32'(ref_b);
    end else if (a == `SRSG_OFF_STATUS) begin
      v = 32'({is_move, 3'b000, state});
    end else if (a == `SRSG_OFF_SPEED) begin
      v = 32'(cur_period);
    end else if (a == `SRSG_OFF_COUNT) begin
      v = 32'(steps_done);
    end else if (a == `SRSG_OFF_ACK) begin
      v = (ack_count != 8'h00) ? {ack_count, `SRSG_ACK_SEQ} : 32'h0000_0000;
    end
    return v;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = n[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Write channel: address and data taken in either order, answer after both
  wire           aw_fire  = s_axi_awvalid & s_axi_awready;
  wire           w_fire   = s_axi_wvalid & s_axi_wready;
  wire           ar_fire  = s_axi_arvalid & s_axi_arready;
  wire [AW-1:0]  wr_addr  = aw_hold ? aw_addr_q : s_axi_awaddr;
  wire [31:0]    wr_data  = w_hold ? wdata_q : s_axi_wdata;
  wire [3:0]     wr_strb  = w_hold ? wstrb_q : s_axi_wstrb;
  wire           do_wr    = (aw_hold | aw_fire) & (w_hold | w_fire) & ~s_axi_bvalid;
  wire [31:0]    wr_word  = merge(reg_word(wr_addr), wr_data, wr_strb);
  wire           wr_ctrl  = do_wr && (wr_addr == `SRSG_OFF_CTRL);
  wire [3:0]     cmd      = wr_ctrl ? (wr_data[3:0] & {4{wr_strb[0]}}) : 4'h0;
  assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  // Command acceptance: stop beats move, move beats start
  wire idle     = (state == st_idle);
  wire ramping  = (state == st_accel) || (state == st_decel);
  wire stop_ok  = cmd[`SRSG_CMD_STOP] & ~idle;
  wire move_ok  = cmd[`SRSG_CMD_MOVE] & idle & ~stop_ok;
  wire start_ok = cmd[`SRSG_CMD_START] & idle & ~cmd[`SRSG_CMD_MOVE];
  wire upd_ok   = cmd[`SRSG_CMD_UPDATE];
  wire go       = start_ok | move_ok;
  wire accepted = stop_ok | go | upd_ok;

  // Speed update interval falls as the acceleration rate rises
  wire [W-1:0] acc_src  = idle ? prog.accel : act.accel;
  wire [W-1:0] acc_lim  = (acc_src > `SRSG_ACCEL_MAX) ? `SRSG_ACCEL_MAX : acc_src;
  wire [W-1:0] upd_ivl  = `SRSG_UPD_BASE - acc_lim;
  wire         upd_evt  = ramping & tick & (upd_cnt <= W'(1));
  wire [W-1:0] step_inc = steps_done + W'(1);

  // Ramp sequencer
  always_comb begin
    next_state   = state;
    next_period  = cur_period;
    next_steps   = steps_done;
    next_is_move = is_move;
    case (state)
      st_idle: begin
        if (go) begin
          next_state   = st_accel;
          next_period  = prog.start;
          next_steps   = '0;
          next_is_move = move_ok;
        end
      end
      st_accel: begin
        if (stop_ok) begin
          next_state   = st_decel;
          next_is_move = 1'b0;
        end else if (upd_evt) begin
          if (cur_period > act.target) begin
            next_period = cur_period - W'(1);
          end else if (cur_period < act.target) begin
            next_period = cur_period + W'(1);
          end else begin
            next_state = st_run;
          end
        end
      end
      st_run: begin
        if (stop_ok) begin
          next_state   = st_decel;
          next_is_move = 1'b0;
        end else if (upd_ok && (prog.target != cur_period)) begin
          next_state = st_accel;
        end
      end
      st_decel: begin
        if (upd_evt) begin
          if (cur_period < act.stop) begin
            next_period = cur_period + W'(1);
          end else if (cur_period > act.stop) begin
            next_period = cur_period - W'(1);
          end else if (!is_move) begin
            next_state = st_idle;
          end
        end
      end
      default: begin
        next_state = st_idle;
      end
    endcase
    // Step count of a move overrides the ramp
    if (is_move && step_evt && !idle) begin
      next_steps = step_inc;
      if (step_inc == act.steps) begin
        next_state = st_idle;
      end else if ((step_inc == act.stop_at) && (state != st_decel)) begin
        next_state = st_decel;
      end
    end
  end

  // Bus handshake state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_hold      <= 1'b0;
      w_hold       <= 1'b0;
      aw_addr_q    <= '0;
      wdata_q      <= 32'h0000_0000;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SRSG_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `SRSG_RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      if (aw_fire) aw_addr_q <= s_axi_awaddr;
      if (w_fire) wdata_q <= s_axi_wdata;
      if (w_fire) wstrb_q <= s_axi_wstrb;
      aw_hold <= do_wr ? 1'b0 : (aw_hold | aw_fire);
      w_hold  <= do_wr ? 1'b0 : (w_hold | w_fire);
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= reg_known(wr_addr) ? `SRSG_RESP_OKAY : `SRSG_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (ar_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= reg_word(s_axi_araddr);
        s_axi_rresp  <= reg_known(s_axi_araddr) ? `SRSG_RESP_OKAY : `SRSG_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Software registers; speeds arrive already as tick counts
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg  <= '0;
      prog <= '{`SRSG_RST_SPEED, `SRSG_RST_TARGET, `SRSG_RST_SPEED,
                `SRSG_RST_ACCEL, `SRSG_RST_STEPS, `SRSG_RST_STOP_AT};
      ref_a <= '0;
      ref_b <= '0;
    end else if (clk_en && do_wr) begin
      if (wr_addr == `SRSG_OFF_CFG) cfg <= srsg_cfg_t'(wr_word[`SRSG_CFG_W-1:0]);
      if (wr_addr == `SRSG_OFF_START) prog.start <= wr_word[W-1:0];
      if (wr_addr == `SRSG_OFF_TARGET) prog.target <= wr_word[W-1:0];
      if (wr_addr == `SRSG_OFF_STOP) prog.stop <= wr_word[W-1:0];
      if (wr_addr == `SRSG_OFF_ACCEL) prog.accel <= wr_word[W-1:0];
      if (wr_addr == `SRSG_OFF_STEPS) prog.steps <= wr_word[W-1:0];
      if (wr_addr == `SRSG_OFF_STOP_AT) prog.stop_at <= wr_word[W-1:0];
      if (wr_addr == `SRSG_OFF_REF_A) ref_a <= wr_word[`SRSG_REF_W-1:0];
      if (wr_addr == `SRSG_OFF_REF_B) ref_b <= wr_word[`SRSG_REF_W-1:0];
    end
  end

  // Profile state, latched copy and acknowledgement counter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state      <= st_idle;
      cur_period <= `SRSG_RST_SPEED;
      steps_done <= '0;
      is_move    <= 1'b0;
      act        <= '0;
      upd_cnt    <= '0;
      ack_count  <= 8'h00;
    end else if (clk_en) begin
      state      <= next_state;
      cur_period <= next_period;
      steps_done <= next_steps;
      is_move    <= next_is_move;
      if (go) begin
        act <= prog;
      end else if (upd_ok) begin
        act.target <= prog.target;
        act.accel  <= prog.accel;
        act.stop   <= prog.stop;
      end
      if (!ramping || upd_evt) begin
        upd_cnt <= upd_ivl;
      end else if (tick) begin
        upd_cnt <= upd_cnt - W'(1);
      end
      if (accepted) ack_count <= ack_count + 8'h01;
    end
  end

  // Resolution limits differ between indexer modes
  wire [3:0] res_ext = (cfg.res < `SRSG_RES_EXT_MIN) ? `SRSG_RES_EXT_MIN :
                       (cfg.res > `SRSG_RES_EXT_MAX) ? `SRSG_RES_EXT_MAX : cfg.res;
  wire [3:0] res_int = (cfg.res > `SRSG_RES_INT_MAX) ? `SRSG_RES_INT_MAX : cfg.res;
  wire [3:0] res_eff = cfg.ext_indexer ? res_ext : res_int;
  wire [10:0] ph_inc = `SRSG_FULL_INC >> res_eff;
  wire [10:0] ph_b   = phase + `SRSG_FULL_INC;
  wire [8:0]  addr_a = phase[9] ? ~phase[8:0] : phase[8:0];
  wire [8:0]  addr_b = ph_b[9] ? ~ph_b[8:0] : ph_b[8:0];

  // In external indexer mode the microstep phase walks with each step in the chosen direction
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase <= '0;
    end else if (clk_en && step_evt && cfg.ext_indexer) begin
      phase <= cfg.dir ? phase - ph_inc : phase + ph_inc;
    end
  end

  // Driver pins follow settings; table drives references in external mode
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      direction              <= 1'b0;
      channel_a_decay_select <= 1'b0;
      channel_b_decay_select <= 1'b0;
      mode_config            <= 1'b0;
      driver_awake           <= 1'b0;
      microstep_res          <= 4'h0;
      channel_a_reference    <= '0;
      channel_b_reference    <= '0;
    end else if (clk_en) begin
      direction     <= cfg.dir;
      mode_config   <= cfg.mode_cfg;
      driver_awake  <= cfg.awake;
      microstep_res <= res_eff;
      // Mixed decay on falling quadrants keeps the sine shape in external mode
      channel_a_decay_select <= cfg.ext_indexer ? phase[9] : cfg.decay_a;
      channel_b_decay_select <= cfg.ext_indexer ? ph_b[9] : cfg.decay_b;
      channel_a_reference <= cfg.ext_indexer ? rom_a : ref_a;
      channel_b_reference <= cfg.ext_indexer ? rom_b : ref_b;
    end
  end

  srsg_step_timer #(.W(W)) u_timer (
    .clk      (clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .run      (~idle),
    .period   (next_period),
    .tick     (tick),
    .step_evt (step_evt),
    .step_out (step_pulse)
  );

  srsg_wave_rom #(.AW(9), .DW(`SRSG_REF_W)) u_rom (
    .clk    (clk),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .addr_a (addr_a),
    .addr_b (addr_b),
    .data_a (rom_a),
    .data_b (rom_b)
  );
endmodule
`default_nettype wire

//--- testbench/srsg_properties.sv
// Port checks for the step generator top, bound below
`timescale 1ns/100ps
`default_nettype none
module srsg_properties (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        step_pulse,
  input wire logic        direction,
  input wire logic        driver_awake
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Both write channels taken on one edge; strobes are assumed full
  sequence s_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_cfg;
    s_wr ##0 s_axi_awaddr == 8'h04;
  endsequence
  // Four clocks high, then low at the next timer tick
  sequence s_pulse;
    step_pulse [*4] ##1 !step_pulse;
  endsequence
  property p_b_lat; s_wr |=> s_axi_bvalid; endproperty
  a_b_lat: assert property (p_b_lat) else $error("late bvalid");
  property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_lat: assert property (p_r_lat) else $error("late rvalid");
  property p_r_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_r_busy: assert property (p_r_busy) else $error("read overlap");
  property p_err; s_wr ##0 s_axi_awaddr > 8'h34 |=> s_axi_bresp == 2'h2; endproperty
  a_err: assert property (p_err) else $error("no error response");
  property p_pulse; $rose(step_pulse) |-> s_pulse; endproperty
  a_pulse: assert property (p_pulse) else $error("pulse width");
  // Periods stay above 122 ticks, so a gap is far longer than 8 cycles
  property p_gap; $fell(step_pulse) |-> !step_pulse [*8]; endproperty
  a_gap: assert property (p_gap) else $error("pulse gap");
  property p_dir; s_cfg |-> ##2 direction == $past(s_axi_wdata[0], 2); endproperty
  a_dir: assert property (p_dir) else $error("direction level");
  property p_wake; s_cfg |-> ##2 driver_awake == $past(s_axi_wdata[3], 2); endproperty
  a_wake: assert property (p_wake) else $error("awake level");
endmodule
bind srsg_top srsg_properties i_props (.*);
`default_nettype wire

//--- testbench/srsg_motor_model.sv
// Step counter in place of the driver's step input
`timescale 1ns/100ps
`default_nettype none
module srsg_motor_model (
  input  wire logic clk,
  input  wire logic step_pulse,
  output var  int   steps
);
  logic last = 0;
  initial steps = 0;
  // The driver indexes once per rising step edge, never on the level
  always @(posedge clk) begin
    last <= step_pulse;
    if (step_pulse && !last) steps <= steps + 1;
  end
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench for the step generator
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import srsg_pkg::*;
  localparam int LIM = 2000;
  logic        clk = 0, rst_n = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic [7:0]  aa = 0;
  logic [31:0] wd = 0, rdat, q;
  logic [1:0]  bre, rre, r;
  logic        awr, wrd, bv, arr, rv, sp, dir, dca, dcb, mc, wake;
  logic [3:0]  res;
  logic [11:0] ref_a, ref_b;
  int          errors = 0, compares = 0, steps;
  // 40 MHz clock
  always #12.5 clk = ~clk;
  srsg_top i_dut (.clk(clk), .rst_n(rst_n), .clk_en(1'b1), .s_axi_awaddr(aa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bre), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(aa), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rre), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .step_pulse(sp), .direction(dir), .channel_a_decay_select(dca),
    .channel_b_decay_select(dcb), .mode_config(mc), .driver_awake(wake),
    .microstep_res(res), .channel_a_reference(ref_a), .channel_b_reference(ref_b));
  srsg_motor_model i_motor (.clk(clk), .step_pulse(sp), .steps(steps));
  task automatic final_report;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= LIM) begin
      chk("wait bound", 32'h1, 32'h0);
      final_report;
    end
  endtask
  // One transfer; ready is judged at the negedge, so release lands on the taking edge
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int   n;
    logic ta, tw, tb;
    @(posedge clk);
    aa <= a;
    wd <= d;
    awv <= we;
    wv <= we;
    br <= we;
    arv <= !we;
    rr <= !we;
    for (n = 0; n < LIM && (n == 0 || awv || wv || br || arv || rr); n++) begin
      @(negedge clk);
      ta = (awv && awr) || (arv && arr);
      tw = wv && wrd;
      tb = (br && bv) || (rr && rv);
      if (tb) q = rdat;
      if (tb) r = we ? bre : rre;
      @(posedge clk);
      if (ta) awv <= 0;
      if (ta) arv <= 0;
      if (tw) wv <= 0;
      if (tb) br <= 0;
      if (tb) rr <= 0;
    end
    tmo(n);
  endtask
  task automatic wait_state(input logic [3:0] s);
    int n;
    q = 'x;
    for (n = 0; n < LIM && q[3:0] !== s; n++) bus(0, 8'h28, 32'h0);
    if (q[3:0] !== s) tmo(LIM);
  endtask
  // Reset values, an unmapped read and an unmapped write
  task automatic t_reset;
    logic [7:0]  ad [6] = '{8'h04, 8'h08, 8'h0c, 8'h14, 8'h1c, 8'h34};
    logic [31:0] ex [6] = '{32'h0, 32'h9c40, 32'h1f40, 32'h32, 32'h320, 32'h0};
    for (int i = 0; i < 6; i++) begin
      bus(0, ad[i], 32'h0);
      chk("reset value", ex[i], q);
    end
    bus(0, 8'h38, 32'h0);
    chk("unmapped read", 32'h2, {q[29:0], r});
    bus(1, 8'h40, 32'h1);
    chk("unmapped write", 32'h2, {30'h0, r});
    $display("test reset done");
  endtask
  // Control levels, resolution clamps and reference codes
  task automatic t_cfg;
    bus(1, 8'h04, 32'h25b);
    bus(1, 8'h20, 32'hfff);
    repeat (3) @(posedge clk);
    chk("lines", 32'h1b, {27'h0, mc, wake, dcb, dca, dir});
    chk("int res", 32'h5, {28'h0, res});
    chk("refs", 32'hff_f000, {8'h0, ref_a, ref_b});
    bus(1, 8'h04, 32'h24);
    repeat (3) @(posedge clk);
    chk("ext res", 32'h1, {28'h0, res});
    chk("ext decay", 32'h2, {30'h0, dcb, dca});
    chk("ext ref a", 32'h0, {20'h0, ref_a});
    $display("test cfg done");
  endtask
  // Ramp up, refuse a second start, ramp down on stop
  task automatic t_run;
    bus(1, 8'h08, 32'h8c);
    bus(1, 8'h0c, 32'h7b);
    bus(1, 8'h10, 32'h8c);
    bus(1, 8'h14, 32'h1387);
    bus(1, 8'h00, 32'h1);
    bus(0, 8'h2c, 32'h0);
    chk("first period", 32'h8c, q);
    wait_state(4'h4);
    bus(0, 8'h2c, 32'h0);
    chk("run period", 32'h7b, q);
    bus(1, 8'h00, 32'h1);
    bus(1, 8'h00, 32'h2);
    bus(0, 8'h28, 32'h0);
    chk("decel state", 32'h8, q);
    wait_state(4'h1);
    $display("test run done");
  endtask
  // Moves with the slowdown point inside and beyond the count
  task automatic t_move;
    logic [31:0] tot [2] = '{32'h6, 32'h3};
    logic [31:0] at [2] = '{32'h3, 32'h9};
    int          s0;
    for (int i = 0; i < 2; i++) begin
      bus(1, 8'h18, tot[i]);
      bus(1, 8'h1c, at[i]);
      s0 = steps;
      bus(1, 8'h00, 32'h4);
      wait_state(4'h1);
      repeat (20) @(posedge clk);
      chk("motor steps", tot[i], 32'(steps - s0));
      bus(0, 8'h30, 32'h0);
      chk("move count", tot[i], q);
    end
    bus(0, 8'h34, 32'h0);
    chk("ack", 32'h431_3030, q);
    $display("test move done");
  endtask
  // Reset, then the scenarios in turn
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1;
    t_reset;
    t_cfg;
    t_run;
    t_move;
    final_report;
  end
endmodule
`default_nettype wire
